// ### sble_pkg.sv
// Shared types and constants of the scan bit-logic edge unit.
// Assumes a scan sequencer that issues one bit-logic step per request.

`default_nettype none

package sble_pkg;

    // ------------------------------------------------------------------
    // Sizes and reset values
    // ------------------------------------------------------------------
    localparam int   SLOT_W    = 8;
    localparam int   SLOT_NUM  = 256;
    localparam logic RESET_BIT = 1'h0;

    // ------------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_PULSE_FALL,
        OP_COMPLEMENT,
        OP_NOP,
        OP_RISE,
        OP_FALL,
        OP_STORED_RISE,
        OP_STORED_FALL,
        OP_HALT
    } sble_op_t;

    typedef enum logic {
        RUN_ACTIVE,
        RUN_HALTED
    } sble_run_t;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic              valid;
        sble_op_t          op;
        logic              accIn;
        logic              devBit;
        logic [SLOT_W-1:0] slot;
    } sble_req_t;

    typedef struct packed {
        logic valid;
        logic acc;
        logic devWrEn;
        logic devWrData;
    } sble_res_t;

endpackage

`default_nettype wire

// ### sble_prev_mem.sv
// Hidden previous-state bits, one per plain edge instruction slot.
// Assumes one write and one read per cycle; read data is registered.

`timescale 1ns/100ps
`default_nettype none

module sble_prev_mem
    import sble_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              wrEn,
    input  wire logic [SLOT_W-1:0] wrAddr,
    input  wire logic              wrData,
    input  wire logic [SLOT_W-1:0] rdAddr,
    output logic                   rdData
);

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    // Kept in flops so that reset clears every edge history at once.
    logic [SLOT_NUM-1:0] bits;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            bits <= '0;
        end
        else if (wrEn)
        begin
            bits[wrAddr] <= wrData;
        end
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            rdData <= RESET_BIT;
        end
        else
        begin
            rdData <= bits[rdAddr];
        end
    end

endmodule

`default_nettype wire

// ### sble_unit.sv
// Bit-logic execution unit: edges, pulses, complement, no-op and halt.
// Assumes requests on the same clock; one result two cycles later.

`timescale 1ns/100ps
`default_nettype none

module sble_unit
    import sble_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      rst_b,
    input  wire sble_req_t req,
    output var  sble_res_t res,
    output logic           halted
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic edgeSeen(input logic prev,
                                      input logic cur,
                                      input logic rising);
        begin
            edgeSeen = rising ? (cur & ~prev) : (prev & ~cur);
        end
    endfunction

    function automatic logic usesHidden(input sble_op_t op);
        begin
            usesHidden = (op == OP_PULSE_FALL) || (op == OP_RISE) ||
                         (op == OP_FALL);
        end
    endfunction

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    sble_run_t         runState;
    sble_req_t         stage;
    sble_res_t         next_res;
    logic              takeReq;
    logic              haltNow;
    logic              memWrEn;
    logic              memRd;
    logic              fwdHit;
    logic              fwdVal;
    logic              hiddenPrev;

    // ------------------------------------------------------------------
    // Issue stage
    // ------------------------------------------------------------------
    // A halting step in flight blocks the next request already, so no
    // instruction after the halt is ever executed.
    assign haltNow = stage.valid && (stage.op == OP_HALT) && stage.accIn;
    assign takeReq = req.valid && (runState == RUN_ACTIVE) && !haltNow;

    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            stage <= '0;
        end
        else
        begin
            stage       <= req;
            stage.valid <= takeReq;
        end
    end

    // ------------------------------------------------------------------
    // Hidden edge history
    // ------------------------------------------------------------------
    // Each plain edge slot writes its current input back every scan.
    assign memWrEn = stage.valid && usesHidden(stage.op);

    sble_prev_mem u_prevMem
    (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .wrEn    (memWrEn),
        .wrAddr  (stage.slot),
        .wrData  (stage.accIn),
        .rdAddr  (req.slot),
        .rdData  (memRd)
    );

    // The memory reads before the same edge's write lands, so a slot
    // issued right after itself takes the value being written.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            fwdHit <= 1'h0;
            fwdVal <= RESET_BIT;
        end
        else
        begin
            fwdHit <= memWrEn && takeReq && (req.slot == stage.slot);
            fwdVal <= stage.accIn;
        end
    end

    assign hiddenPrev = fwdHit ? fwdVal : memRd;

    // ------------------------------------------------------------------
    // Evaluation
    // ------------------------------------------------------------------
    always_comb
    begin
        next_res           = '0;
        next_res.valid     = stage.valid;
        next_res.acc       = stage.accIn;
        next_res.devWrEn   = 1'h0;
        next_res.devWrData = 1'h0;
        case (stage.op)
            OP_PULSE_FALL:
            begin
                next_res.devWrEn   = stage.valid;
                next_res.devWrData = edgeSeen(hiddenPrev, stage.accIn,
                                              1'h0);
            end
            OP_COMPLEMENT:
            begin
                next_res.acc = ~stage.accIn;
            end
            OP_NOP:
            begin
                next_res.acc = stage.accIn;
            end
            OP_RISE:
            begin
                next_res.acc = edgeSeen(hiddenPrev, stage.accIn,
                                        1'h1);
            end
            OP_FALL:
            begin
                next_res.acc = edgeSeen(hiddenPrev, stage.accIn,
                                        1'h0);
            end
            OP_STORED_RISE:
            begin
                next_res.acc = edgeSeen(stage.devBit, stage.accIn,
                                        1'h1);
                next_res.devWrEn   = stage.valid;
                next_res.devWrData = stage.accIn;
            end
            OP_STORED_FALL:
            begin
                next_res.acc = edgeSeen(stage.devBit, stage.accIn,
                                        1'h0);
                next_res.devWrEn   = stage.valid;
                next_res.devWrData = stage.accIn;
            end
            OP_HALT:
            begin
                next_res.acc = stage.accIn;
            end
            default:
            begin
                next_res.acc = stage.accIn;
            end
        endcase
    end

    // Every taken step yields a result, a no-op included.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            res <= '0;
        end
        else
        begin
            res <= next_res;
        end
    end

    // ------------------------------------------------------------------
    // Run control
    // ------------------------------------------------------------------
    // Only reset brings the unit back to running.
    always_ff @(posedge ref_clk)
    begin
        if (!rst_b)
        begin
            runState <= RUN_ACTIVE;
            halted   <= 1'h0;
        end
        else
        begin
            case (runState)
                RUN_ACTIVE:
                begin
                    if (haltNow)
                    begin
                        runState <= RUN_HALTED;
                        halted   <= 1'h1;
                    end
                end
                RUN_HALTED:
                begin
                    runState <= RUN_HALTED;
                    halted   <= 1'h1;
                end
                default:
                begin
                    runState <= RUN_ACTIVE;
                    halted   <= 1'h0;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    sequence s_riseHi;
        takeReq && (req.op == OP_RISE) && req.accIn;
    endsequence

    sequence s_nopTaken;
        takeReq && (req.op == OP_NOP);
    endsequence

    property p_pulseFall;
        @(posedge ref_clk) disable iff (!rst_b)
        stage.valid && (stage.op == OP_PULSE_FALL) |=>
            res.devWrEn &&
            (res.devWrData == ($past(hiddenPrev) && !$past(stage.accIn)));
    endproperty
    a_pulseFall: assert property (p_pulseFall)
        else $error("Falling pulse output wrong.");

    property p_complement;
        @(posedge ref_clk) disable iff (!rst_b)
        takeReq && (req.op == OP_COMPLEMENT) |->
            ##2 (res.valid && (res.acc == !$past(req.accIn, 2)));
    endproperty
    a_complement: assert property (p_complement)
        else $error("Complement did not invert.");

    property p_nop;
        @(posedge ref_clk) disable iff (!rst_b)
        s_nopTaken |-> ##2 (res.acc == $past(req.accIn, 2)) &&
                           !res.devWrEn;
    endproperty
    a_nop: assert property (p_nop)
        else $error("No-op changed the result.");

    property p_slot;
        @(posedge ref_clk) disable iff (!rst_b)
        takeReq |-> ##2 res.valid;
    endproperty
    a_slot: assert property (p_slot)
        else $error("Taken step gave no result.");

    property p_rise;
        @(posedge ref_clk) disable iff (!rst_b)
        stage.valid && (stage.op == OP_RISE) |=>
            res.acc == ($past(stage.accIn) && !$past(hiddenPrev));
    endproperty
    a_rise: assert property (p_rise)
        else $error("Rise trigger wrong.");

    property p_fall;
        @(posedge ref_clk) disable iff (!rst_b)
        stage.valid && (stage.op == OP_FALL) |=>
            res.acc == (!$past(stage.accIn) && $past(hiddenPrev));
    endproperty
    a_fall: assert property (p_fall)
        else $error("Fall trigger wrong.");

    property p_storedRise;
        @(posedge ref_clk) disable iff (!rst_b)
        takeReq && (req.op == OP_STORED_RISE) |-> ##2
            (res.acc == ($past(req.accIn, 2) && !$past(req.devBit, 2)));
    endproperty
    a_storedRise: assert property (p_storedRise)
        else $error("Stored rise trigger wrong.");

    property p_storedFall;
        @(posedge ref_clk) disable iff (!rst_b)
        takeReq && (req.op == OP_STORED_FALL) |-> ##2
            (res.acc == (!$past(req.accIn, 2) && $past(req.devBit, 2)));
    endproperty
    a_storedFall: assert property (p_storedFall)
        else $error("Stored fall trigger wrong.");

    property p_storedKeep;
        @(posedge ref_clk) disable iff (!rst_b)
        takeReq && ((req.op == OP_STORED_RISE) ||
                    (req.op == OP_STORED_FALL)) |->
            ##2 (res.devWrEn && (res.devWrData == $past(req.accIn, 2)));
    endproperty
    a_storedKeep: assert property (p_storedKeep)
        else $error("Stored trigger state not written back.");

    property p_halt;
        @(posedge ref_clk) disable iff (!rst_b)
        haltNow |=> halted ##1 (halted && !res.valid);
    endproperty
    a_halt: assert property (p_halt)
        else $error("Halt did not stop execution.");

    property p_hiddenOnce;
        @(posedge ref_clk) disable iff (!rst_b)
        s_riseHi ##1 (s_riseHi and (req.slot == $past(req.slot))) |->
            ##2 (res.valid && !res.acc);
    endproperty
    a_hiddenOnce: assert property (p_hiddenOnce)
        else $error("Rise trigger held longer than one scan.");

endmodule

`default_nettype wire

// ### sble_unit_tb.sv
// Self-checking bench of the scan bit-logic edge unit.
// Assumes one result two edges after each taken step, halt sticky.

`timescale 1ns/100ps
`default_nettype none

module sble_unit_tb
    import sble_pkg::*;
();

    // ------------------------------------------------------------------
    // Signals and reference state
    // ------------------------------------------------------------------
    logic      ref_clk;
    logic      rst_b;
    sble_req_t req;
    sble_res_t res;
    logic      halted;
    int        n_errors;
    int        compares;
    int        cyc;
    int        haltDue;
    int        wdog;
    logic      mHalt;
    logic      prevBit [SLOT_NUM];
    logic      expV [8];
    logic      expA [8];
    logic      expW [8];
    logic      expD [8];
    logic      useA [8];
    logic      useW [8];

    sble_unit dut_u (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .req     (req),
        .res     (res),
        .halted  (halted)
    );

    initial
    begin
        ref_clk = 1'h0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic seen, input logic exp, input string what);
        compares++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("MISMATCH at %0t: %s", $time, what);
        end
    endtask

    task automatic tally_and_finish();
        $display("Compares %0d, mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Outputs are judged at the falling edge, where they have settled.
    task automatic tick();
        int i;
        @(negedge ref_clk);
        cyc++;
        i = cyc % 8;
        chk(halted, logic'(cyc >= haltDue), "halted level");
        if (expV[i])
        begin
            chk(res.valid, 1'h1, "missing result");
            if (useA[i])
                chk(res.acc, expA[i], "acc value");
            if (useW[i])
            begin
                chk(res.devWrEn, expW[i], "write enable");
                chk(res.devWrData, expD[i], "write data");
            end
        end
        else
            chk(res.valid, 1'h0, "unexpected result");
        expV[i] = 1'h0;
    endtask

    task automatic step(input sble_op_t op, input logic a, input logic d,
                        input logic [SLOT_W-1:0] s);
        int   j;
        logic p;
        tick();
        j = (cyc + 2) % 8;
        req.valid = 1'h1;
        req.op = op;
        req.accIn = a;
        req.devBit = d;
        req.slot = s;
        expV[j] = !mHalt;
        expA[j] = a;
        useA[j] = 1'h1;
        expW[j] = 1'h0;
        expD[j] = 1'h0;
        useW[j] = 1'h0;
        p = prevBit[s];
        if (!mHalt)
        begin
            case (op)
                OP_PULSE_FALL:
                begin
                    useA[j] = 1'h0;
                    useW[j] = 1'h1;
                    expW[j] = 1'h1;
                    expD[j] = p & !a;
                end
                OP_COMPLEMENT: expA[j] = !a;
                OP_NOP: useW[j] = 1'h1;
                OP_RISE: expA[j] = a & !p;
                OP_FALL: expA[j] = !a & p;
                OP_STORED_RISE, OP_STORED_FALL:
                begin
                    expA[j] = (op == OP_STORED_RISE) ? (a & !d) : (!a & d);
                    useW[j] = 1'h1;
                    expW[j] = 1'h1;
                    expD[j] = a;
                end
                default: ;
            endcase
            if (op inside {OP_PULSE_FALL, OP_RISE, OP_FALL})
                prevBit[s] = a;
            if (op == OP_HALT && a)
            begin
                mHalt = 1'h1;
                haltDue = cyc + 2;
            end
        end
    endtask

    task automatic idle(input int n);
        repeat (n)
        begin
            tick();
            req.valid = 1'h0;
        end
    endtask

    task automatic run(input sble_op_t op, input logic [SLOT_W-1:0] s,
                       input logic [7:0] bits, input int n);
        for (int k = n - 1; k >= 0; k--)
            step(op, bits[k], 1'h0, s);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic sc_complement_nop();
        step(OP_COMPLEMENT, 1'h0, 1'h0, 8'h00);
        step(OP_COMPLEMENT, 1'h1, 1'h0, 8'h00);
        step(OP_NOP, 1'h0, 1'h0, 8'h00);
        step(OP_NOP, 1'h1, 1'h0, 8'h00);
        idle(3);
    endtask

    // Same slot back to back, then two slots interleaved.
    task automatic sc_plain_edges();
        run(OP_RISE, 8'h05, 8'h0d, 5);
        run(OP_FALL, 8'h06, 8'h12, 5);
        step(OP_RISE, 1'h1, 1'h0, 8'h07);
        step(OP_RISE, 1'h0, 1'h0, 8'h08);
        step(OP_RISE, 1'h1, 1'h0, 8'h07);
        step(OP_RISE, 1'h1, 1'h0, 8'h08);
        idle(3);
    endtask

    task automatic sc_pulse_fall();
        run(OP_PULSE_FALL, 8'h14, 8'h12, 5);
        idle(3);
    endtask

    task automatic sc_stored();
        for (int k = 0; k < 4; k++)
            step(OP_STORED_RISE, k[1], k[0], 8'h00);
        for (int k = 0; k < 4; k++)
            step(OP_STORED_FALL, k[1], k[0], 8'h00);
        idle(3);
    endtask

    // A disabled halt passes; the enabled one stops all that follows.
    task automatic sc_halt();
        step(OP_HALT, 1'h0, 1'h0, 8'h00);
        step(OP_NOP, 1'h1, 1'h0, 8'h00);
        step(OP_HALT, 1'h1, 1'h0, 8'h00);
        step(OP_NOP, 1'h1, 1'h0, 8'h00);
        step(OP_RISE, 1'h1, 1'h0, 8'h09);
        idle(5);
    endtask

    // Reset must clear the halt and every hidden bit.
    task automatic sc_second_reset();
        tick();
        rst_b = 1'h0;
        req = '0;
        mHalt = 1'h0;
        haltDue = 1 << 30;
        foreach (prevBit[k])
            prevBit[k] = 1'h0;
        idle(4);
        rst_b = 1'h1;
        step(OP_RISE, 1'h1, 1'h0, 8'h05);
        idle(3);
    endtask

    // ------------------------------------------------------------------
    // Main sequence and watchdog
    // ------------------------------------------------------------------
    initial
    begin
        rst_b = 1'h0;
        req = '0;
        cyc = 0;
        wdog = 0;
        n_errors = 0;
        compares = 0;
        mHalt = 1'h0;
        haltDue = 1 << 30;
        foreach (prevBit[k])
            prevBit[k] = 1'h0;
        foreach (expV[k])
            expV[k] = 1'h0;
        repeat (4) @(negedge ref_clk);
        rst_b = 1'h1;
        sc_complement_nop();
        sc_plain_edges();
        sc_pulse_fall();
        sc_stored();
        sc_halt();
        sc_second_reset();
        tally_and_finish();
    end

    // The whole run takes about seventy cycles.
    always @(posedge ref_clk)
    begin
        wdog <= wdog + 1;
        if (wdog == 2000)
        begin
            n_errors++;
            tally_and_finish();
        end
    end

endmodule

`default_nettype wire
